// *** hdl/charge_current_dac_watchdog.sv ***
// Charge current delta-sigma DAC, low current mode and charge watchdog
// Summary of operation
// - Delta-sigma modulates ten-bit current code
// - Low current: one-eighth duty fast pulse
// - Modulator bit gates the pulse train
// - Low current: modulator steps every 40 ms
// - Low current: dual select charges first only
// - Charger register bit starts charging
// - Watchdog expiry stops charging
// - Low current skips minimum voltage check
// - Dual charging uses second battery feedback
// - Dual select outside low current needs voltage above minimum
// - Charger enabled only on interface request
module charge_current_dac_watchdog
    import charge_dac_pkg::*;
#(
    parameter int WATCHDOG_LEN = WATCHDOG_CYCLES,
    parameter int SLOW_LEN = SLOW_BIT_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Battery voltage qualification against min_charge_voltage
    input volt_qual_t min_charge_voltage,
    // Charger outputs
    output logic charge_current_dac,
    output charge_ctrl_t charge_ctrl
);
    // Both timers need at least two states
    if (WATCHDOG_LEN < 2 || SLOW_LEN < 2) begin : g_len_check
        $error("Timer lengths must be at least 2");
    end

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    logic [CODE_W:0] current_r;
    logic [1:0] charger_r;
    logic [31:0] wd_cnt_r;
    logic wd_expired_r;
    logic [31:0] slow_cnt_r;
    logic [CODE_W:0] accum_r;
    logic ds_bit_r;
    logic [2:0] pwm_cnt_r;
    logic wr_en, rd_en, hit;
    logic low_mode, step_en, want_first, want_second;

    assign wr_en = psel && penable && pwrite;
    // Read data is captured in the setup cycle
    assign rd_en = psel && !penable && !pwrite;
    assign hit = addr_hit(paddr, ADDR_CURRENT) || addr_hit(paddr, ADDR_CHARGER)
        || addr_hit(paddr, ADDR_STATUS);
    assign low_mode = current_r[LOW_CURRENT_BIT];

    // Zero-wait APB answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            current_r <= CURRENT_RST;
        end else if (wr_en && pready && addr_hit(paddr, ADDR_CURRENT)) begin
            current_r <= pwdata[CODE_W:0];
        end
    end

    // Charger register; expiry clears both enables
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            charger_r <= CHARGER_RST;
        end else if (wr_en && pready && addr_hit(paddr, ADDR_CHARGER)) begin
            charger_r <= pwdata[1:0];
        end else if (wd_cnt_r == 32'h0000_0001) begin
            charger_r <= CHARGER_RST;
        end
    end

    // Watchdog counts down from each charger write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wd_cnt_r <= 32'h0000_0000;
            wd_expired_r <= 1'b0;
        end else if (wr_en && pready && addr_hit(paddr, ADDR_CHARGER)) begin
            wd_cnt_r <= 32'(WATCHDOG_LEN);
            wd_expired_r <= 1'b0;
        end else if (wd_cnt_r != 32'h0000_0000) begin
            wd_cnt_r <= wd_cnt_r - 32'h0000_0001;
            wd_expired_r <= wd_cnt_r == 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            if (addr_hit(paddr, ADDR_CURRENT)) begin
                prdata <= {21'h000000, current_r};
            end else if (addr_hit(paddr, ADDR_CHARGER)) begin
                prdata <= {30'h00000000, charger_r};
            end else if (addr_hit(paddr, ADDR_STATUS)) begin
                prdata <= {27'h0000000, wd_expired_r, charge_ctrl};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Modulator step enable: every cycle normally, every 40 ms in low mode
    always_ff @(posedge clk) begin
        if (!rst_n || !low_mode) begin
            slow_cnt_r <= 32'h0000_0000;
        end else if (slow_cnt_r == 32'(SLOW_LEN - 1)) begin
            slow_cnt_r <= 32'h0000_0000;
        end else begin
            slow_cnt_r <= slow_cnt_r + 32'h0000_0001;
        end
    end
    assign step_en = !low_mode || (slow_cnt_r == 32'(SLOW_LEN - 1));

    // First order delta-sigma, density code/1023
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            accum_r <= 11'h000;
            ds_bit_r <= 1'b0;
        end else if (step_en) begin
            if ({1'b0, accum_r[CODE_W-1:0]} + {1'b0, current_r[CODE_W-1:0]}
                >= {1'b0, CODE_FULL}) begin
                accum_r <= {1'b0, accum_r[CODE_W-1:0]} + {1'b0, current_r[CODE_W-1:0]}
                    - {1'b0, CODE_FULL};
                ds_bit_r <= 1'b1;
            end else begin
                accum_r <= {1'b0, accum_r[CODE_W-1:0]} + {1'b0, current_r[CODE_W-1:0]};
                ds_bit_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwm_cnt_r <= 3'h0;
        end else begin
            pwm_cnt_r <= pwm_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            charge_current_dac <= 1'b0;
        end else if (low_mode) begin
            charge_current_dac <= ds_bit_r && (pwm_cnt_r < 3'(PWM_ON));
        end else begin
            charge_current_dac <= ds_bit_r;
        end
    end

    // Battery selection and qualification
    always_comb begin
        if (low_mode) begin
            want_first = charger_r[CHG_FIRST_BIT];
            want_second = charger_r[CHG_SECOND_BIT] && !charger_r[CHG_FIRST_BIT];
        end else if (&charger_r) begin
            want_first = min_charge_voltage.first_ok;
            want_second = min_charge_voltage.second_ok;
        end else begin
            want_first = charger_r[CHG_FIRST_BIT];
            want_second = charger_r[CHG_SECOND_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            charge_ctrl <= '0;
        end else begin
            charge_ctrl.charge_first_battery <= want_first;
            charge_ctrl.charge_second_battery <= want_second;
            charge_ctrl.feedback_second <= want_first && want_second;
            charge_ctrl.charger_enable <= want_first || want_second;
        end
    end

    a_low_single: assert property (@(posedge clk) disable iff (!rst_n)
        low_mode && &charger_r |=> !charge_ctrl.charge_second_battery)
        else $error("dual charge in low mode");
    a_wd_clears: assert property (@(posedge clk) disable iff (!rst_n)
        wd_cnt_r == 32'h0000_0001 && !(wr_en && pready) |=> charger_r == 2'h0)
        else $error("watchdog did not clear");
    a_wr_restart: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && pready && addr_hit(paddr, ADDR_CHARGER) |=> wd_cnt_r == 32'(WATCHDOG_LEN))
        else $error("watchdog not restarted");
    a_start_charge: assert property (@(posedge clk) disable iff (!rst_n)
        charger_r == 2'h1 |=> charge_ctrl.charger_enable)
        else $error("charge not started");
    a_pwm_duty: assert property (@(posedge clk) disable iff (!rst_n)
        low_mode && $past(low_mode) && pwm_cnt_r != 3'h1 |-> !charge_current_dac)
        else $error("pulse duty wrong");
    a_slow_step: assert property (@(posedge clk) disable iff (!rst_n)
        low_mode && !step_en |=> $stable(ds_bit_r))
        else $error("modulator stepped early");
    a_dual_fb: assert property (@(posedge clk) disable iff (!rst_n)
        !low_mode && &charger_r && min_charge_voltage.first_ok
        && min_charge_voltage.second_ok |=> charge_ctrl.feedback_second)
        else $error("feedback not from second");
    a_full_code: assert property (@(posedge clk) disable iff (!rst_n)
        !low_mode && current_r[CODE_W-1:0] == CODE_FULL && $stable(current_r)
        ##1 $stable(current_r) |=> charge_current_dac)
        else $error("full code not constant");
    c_low_mode: cover property (@(posedge clk) low_mode && charge_current_dac);
    c_dual: cover property (@(posedge clk) charge_ctrl.feedback_second);
    c_expire: cover property (@(posedge clk) wd_expired_r);
endmodule

// *** hdl/charge_dac_pkg.sv ***
// Constants, register map and carrier types for the charge current DAC block
package charge_dac_pkg;
    localparam int CLK_HZ = 125000000;
    localparam int DATA_W = 32;
    localparam int CODE_W = 10;
    localparam logic [CODE_W-1:0] CODE_FULL = 10'h3FF;
    // Register byte offsets
    localparam logic [7:0] ADDR_CURRENT = 8'h00;
    localparam logic [2:0] CHARGER_REG_SEL = 3'h7;
    // Charger register sits at index 7, one word per index
    localparam logic [7:0] ADDR_CHARGER = {3'h0, CHARGER_REG_SEL, 2'h0};
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    // Field positions
    localparam int LOW_CURRENT_BIT = 10;
    localparam int CHG_FIRST_BIT = 0;
    localparam int CHG_SECOND_BIT = 1;
    // Reset values
    localparam logic [CODE_W:0] CURRENT_RST = 11'h000;
    localparam logic [1:0] CHARGER_RST = 2'h0;
    // Timing
    localparam int WATCHDOG_MS = 1000;
    localparam int SLOW_BIT_MS = 40;
    localparam int WATCHDOG_CYCLES = (CLK_HZ / 1000) * WATCHDOG_MS;
    localparam int SLOW_BIT_CYCLES = (CLK_HZ / 1000) * SLOW_BIT_MS;
    localparam int PWM_PERIOD = 8;
    localparam int PWM_ON = 1;

    typedef struct packed {
        logic charge_first_battery;
        logic charge_second_battery;
        logic feedback_second;
        logic charger_enable;
    } charge_ctrl_t;

    typedef struct packed {
        logic first_ok;
        logic second_ok;
    } volt_qual_t;
endpackage

// *** verif/apb_host_model.sv ***
// APB host model that issues register transfers to the charge block
module apb_host_model (
    // Clock
    input wire logic clk,
    // APB request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // APB answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines flip so a stale value is never mistaken for a live one
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// *** verif/charge_current_dac_watchdog_tb_top.sv ***
// Self-checking bench for the charge current DAC and charge watchdog
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, x); end end

module charge_current_dac_watchdog_tb_top
    import charge_dac_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WD = 200;
    localparam int SL = 16;
    localparam int LIMIT = 20000;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, dac, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    volt_qual_t qual;
    charge_ctrl_t ctrl;
    int errors = 0, n_tests = 0, cyc = 0, cnt, lo, xp, tol;
    logic [9:0] codes [3] = '{10'h000, 10'h200, 10'h3FF};
    // Nibbles: low mode, voltage ok, charge select, expected controls
    logic [15:0] rows [10] = '{16'h0319, 16'h0325, 16'h033F, 16'h0135, 16'h0239,
        16'h0030, 16'h1039, 16'h1025, 16'h0019, 16'h0300};

    charge_current_dac_watchdog #(.WATCHDOG_LEN(WD), .SLOW_LEN(SL)) dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .min_charge_voltage(qual), .charge_current_dac(dac),
        .charge_ctrl(ctrl));
    apb_host_model host (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q, err);
    endtask
    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            errors++;
            stop_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        qual = '0;
        repeat (12) @(posedge clk);
        `CHK(ctrl, 4'h0)
        `CHK(dac, 1'b0)
        rst_n <= 1'b1;
        $display("Test reset done");
        foreach (rows[i]) begin
            qual <= rows[i][9:8];
            wr(ADDR_CURRENT, {21'h0, rows[i][12], 10'h3FF});
            wr(ADDR_CHARGER, {30'h0, rows[i][5:4]});
            repeat (2) @(posedge clk);
            `CHK(ctrl, rows[i][3:0])
        end
        $display("Test charger rows done");
        host.xfer(1'b0, ADDR_CURRENT, 32'h0, q, err);
        `CHK(q, 32'h000003FF)
        `CHK(err, 1'b0)
        host.xfer(1'b1, 8'h0C, 32'hFFFFFFFF, q, err);
        `CHK(err, 1'b1)
        host.xfer(1'b0, 8'h0C, 32'h0, q, err);
        `CHK(q, 32'h0)
        $display("Test registers done");
        qual <= 2'h3;
        wr(ADDR_CHARGER, 32'h1);
        repeat (WD - 40) @(posedge clk);
        wr(ADDR_CHARGER, 32'h1);
        repeat (WD - 10) @(posedge clk);
        `CHK(ctrl.charger_enable, 1'b1)
        repeat (20) @(posedge clk);
        `CHK(ctrl, 4'h0)
        host.xfer(1'b0, ADDR_STATUS, 32'h0, q, err);
        `CHK(q[4], 1'b1)
        `CHK(q[3:0], 4'h0)
        $display("Test watchdog done");
        for (lo = 0; lo < 2; lo++) begin
            foreach (codes[k]) begin
                wr(ADDR_CURRENT, {21'h0, lo[0], codes[k]});
                repeat (64) @(posedge clk);
                cnt = 0;
                repeat (1024) begin
                    @(posedge clk);
                    cnt += int'(dac);
                end
                xp = int'(codes[k]) * (lo == 1 ? 128 : 1024) / 1023;
                tol = lo == 1 ? 8 : 2;
                `CHK(cnt >= xp - tol && cnt <= xp + tol, 1'b1)
            end
        end
        $display("Test modulator done");
        wr(ADDR_CHARGER, 32'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(ctrl, 4'h0)
        `CHK(dac, 1'b0)
        rst_n <= 1'b1;
        host.xfer(1'b0, ADDR_CURRENT, 32'h0, q, err);
        `CHK(q, 32'h0)
        host.xfer(1'b0, ADDR_CHARGER, 32'h0, q, err);
        `CHK(q, 32'h0)
        $display("Test mid-run reset done");
        stop_test();
    end
endmodule
